// ---- rtl/tes_map.svh ----
`ifndef TES_MAP_SVH
`define TES_MAP_SVH
// Functional notes
// - Mode 2: expose from first line tick after trigger rise until tick after fall.
// - Mode 2: start waits for a line tick unless line-aligned start select is set.
// - Frame sync is output only at the start of a readout; in mode 4 that readout follows a frame sync, not a trigger.
// - Exposure pulse covers accumulation; readout window covers the video readout.
// - Full, partial scan and binning work; partial scan overrides binning.
// - Full frame reads 1220 lines, vertical binning reads 594 lines.
// - Mode 3 exposes like mode 2 but always starts on a line tick, ignoring line-aligned start select, and holds readout until external frame sync.
// - Mode 4: first frame sync starts exposure; each later one ends it, starts a new one, reads the last.
// - Mode 5: start at line tick after trigger rise, stop at frame sync rise.

`define TES_ADDR_CTRL 4'h0
`define TES_ADDR_STATUS 4'h4
`define TES_CTRL_RESET 7'h00
`define TES_MODE_PWC 3'h2
`define TES_MODE_DELAY 3'h3
`define TES_MODE_LONG 3'h4
`define TES_MODE_STARTSTOP 3'h5
`define TES_STAT_CNT_LSB 16
`define TES_CLK_NS 40
`define TES_LINE_NS 53200
`define TES_LINE_CLKS (`TES_LINE_NS / `TES_CLK_NS)
`define TES_LINES_FULL 11'h4c4
`define TES_LINES_BIN 11'h252
`define TES_LINES_HALF 11'h262
`define TES_LINES_THIRD 11'h198
`define TES_LINES_SIXTH 11'h0cc
`endif

// ---- rtl/tes_pkg.sv ----
package tes_pkg;
	typedef enum logic [2:0] {
		TES_IDLE = 3'b000,
		TES_WAIT_START = 3'b001,
		TES_EXPOSE = 3'b010,
		TES_WAIT_STOP = 3'b011,
		TES_HOLD = 3'b100,
		TES_LONG = 3'b101
	} tes_exp_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic we;
		logic re;
	} tes_req_s;

	typedef struct packed {
		logic bin;
		logic [1:0] scan;
		logic aligned;
		logic [2:0] mode;
	} tes_ctrl_s;

	typedef struct packed {
		tes_ctrl_s ctrl;
		tes_exp_e st;
		logic [2:0] trg;
		logic [2:0] hs;
		logic [2:0] fs;
		logic [11:0] lcnt;
		logic rd_go;
		logic [10:0] rd_cnt;
		logic fs_out;
		logic win_n;
		logic exp;
		logic [31:0] rdata;
	} tes_state_s;
endpackage

// ---- rtl/tes_sequencer.sv ----
`timescale 1ns/10ps
`include "tes_map.svh"
module tes_sequencer (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire tes_pkg::tes_req_s reg_req,
	output logic [31:0] reg_rdata,
	input wire logic trigger_in,
	input wire logic line_sync,
	input wire logic frame_sync,
	output logic exposure_active_pulse,
	output logic readout_window_n,
	output logic frame_sync_out
);
	import tes_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [10:0] eff_lines(input logic [1:0] scan, input logic bin);
		logic [10:0] r;
		r = `TES_LINES_FULL;
		case (scan)
			2'd1: r = `TES_LINES_HALF;
			2'd2: r = `TES_LINES_THIRD;
			2'd3: r = `TES_LINES_SIXTH;
			default: r = bin ? `TES_LINES_BIN : `TES_LINES_FULL;
		endcase
		return r;
	endfunction

	function automatic logic exposing(input tes_exp_e st);
		return (st == TES_EXPOSE) || (st == TES_WAIT_STOP) || (st == TES_LONG);
	endfunction

	tes_state_s s_r;
	tes_state_s s_nxt;
	logic trig_rise;
	logic trig_fall;
	logic fs_rise;
	logic hs_rise;
	logic line_tick;

	// Stage 0 of each synchroniser feeds stage 1 only; edges use stages 1 and 2.
	assign trig_rise = s_r.trg[1] & ~s_r.trg[2];
	assign trig_fall = ~s_r.trg[1] & s_r.trg[2];
	assign fs_rise = s_r.fs[1] & ~s_r.fs[2];
	assign hs_rise = s_r.hs[1] & ~s_r.hs[2];
	// The internal line timer free-runs but is pulled into step by each external line sync.
	assign line_tick = hs_rise || (s_r.lcnt == 12'(`TES_LINE_CLKS - 1));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.trg = {s_r.trg[1:0], trigger_in};
		s_nxt.hs = {s_r.hs[1:0], line_sync};
		s_nxt.fs = {s_r.fs[1:0], frame_sync};
		s_nxt.lcnt = line_tick ? 12'h000 : 12'(s_r.lcnt + 12'h001);
		s_nxt.rd_go = 1'b0;

		if (reg_req.we && reg_req.addr == `TES_ADDR_CTRL) begin
			s_nxt.ctrl = tes_ctrl_s'(reg_req.wdata[6:0]);
		end
		s_nxt.rdata = 32'h0000_0000;
		if (reg_req.re) begin
			case (reg_req.addr)
				`TES_ADDR_CTRL: s_nxt.rdata = {25'h000_0000, s_r.ctrl};
				`TES_ADDR_STATUS: begin
					s_nxt.rdata[2:0] = s_r.st;
					s_nxt.rdata[3] = s_r.exp;
					s_nxt.rdata[4] = ~s_r.win_n;
					s_nxt.rdata[5] = s_r.fs_out;
					s_nxt.rdata[`TES_STAT_CNT_LSB +: 11] = s_r.rd_cnt;
				end
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// Exposure sequencing; a trigger is only taken while idle.
		case (s_r.st)
			TES_IDLE: begin
				if (s_r.ctrl.mode == `TES_MODE_LONG) begin
					if (fs_rise) begin
						s_nxt.st = TES_LONG;
					end
				end else if (trig_rise && (s_r.ctrl.mode == `TES_MODE_PWC
						|| s_r.ctrl.mode == `TES_MODE_DELAY
						|| s_r.ctrl.mode == `TES_MODE_STARTSTOP)) begin
					if (s_r.ctrl.mode == `TES_MODE_PWC && s_r.ctrl.aligned) begin
						s_nxt.st = TES_EXPOSE;
					end else if (line_tick) begin
						s_nxt.st = TES_EXPOSE;
					end else begin
						s_nxt.st = TES_WAIT_START;
					end
				end
			end
			TES_WAIT_START: begin
				if (line_tick) begin
					s_nxt.st = TES_EXPOSE;
				end
			end
			TES_EXPOSE: begin
				if (s_r.ctrl.mode == `TES_MODE_STARTSTOP) begin
					if (fs_rise) begin
						s_nxt.st = TES_IDLE;
						s_nxt.rd_go = 1'b1;
					end
				end else if (trig_fall) begin
					s_nxt.st = TES_WAIT_STOP;
				end
			end
			TES_WAIT_STOP: begin
				if (line_tick) begin
					if (s_r.ctrl.mode == `TES_MODE_DELAY) begin
						s_nxt.st = TES_HOLD;
					end else begin
						s_nxt.st = TES_IDLE;
						s_nxt.rd_go = 1'b1;
					end
				end
			end
			TES_HOLD: begin
				if (fs_rise) begin
					s_nxt.st = TES_IDLE;
					s_nxt.rd_go = 1'b1;
				end
			end
			TES_LONG: begin
				if (s_r.ctrl.mode != `TES_MODE_LONG) begin
					s_nxt.st = TES_IDLE;
				end else if (fs_rise) begin
					s_nxt.rd_go = 1'b1;
				end
			end
			default: s_nxt.st = TES_IDLE;
		endcase

		// Readout runs apart from exposure, so a new exposure may overlap it.
		if (s_r.rd_go) begin
			s_nxt.rd_cnt = eff_lines(s_r.ctrl.scan, s_r.ctrl.bin);
			s_nxt.fs_out = 1'b1;
		end else if (line_tick) begin
			if (s_r.fs_out) begin
				s_nxt.fs_out = 1'b0;
			end else if (s_r.rd_cnt != 11'h000) begin
				s_nxt.rd_cnt = s_r.rd_cnt - 11'h001;
			end
		end
		s_nxt.win_n = ~(s_nxt.rd_cnt != 11'h000 && !s_nxt.fs_out);
		s_nxt.exp = exposing(s_nxt.st);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '{ctrl: tes_ctrl_s'(`TES_CTRL_RESET), st: TES_IDLE, win_n: 1'b1,
				default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Every output is a field of the state register, so none can glitch between edges.
	assign reg_rdata = s_r.rdata;
	assign exposure_active_pulse = s_r.exp;
	assign readout_window_n = s_r.win_n;
	assign frame_sync_out = s_r.fs_out;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence s_pwc_trig;
		s_r.ctrl.mode == `TES_MODE_PWC && s_r.st == TES_IDLE && trig_rise;
	endsequence

	sequence s_readout_begin;
		$fell(s_r.fs_out) && s_r.rd_cnt != 11'h000;
	endsequence

	property p_pwc_tick_start;
		(s_r.ctrl.mode == `TES_MODE_PWC && s_r.st == TES_WAIT_START && line_tick)
			|=> s_r.exp;
	endproperty
	a_pwc_tick_start: assert property (p_pwc_tick_start) else $error("no start on tick");

	property p_aligned_now;
		(s_pwc_trig and s_r.ctrl.aligned) |=> s_r.exp;
	endproperty
	a_aligned_now: assert property (p_aligned_now) else $error("no immediate start");

	property p_wait_line;
		(s_pwc_trig and !s_r.ctrl.aligned && !line_tick) |=> !s_r.exp;
	endproperty
	a_wait_line: assert property (p_wait_line) else $error("start not line aligned");

	property p_fs_only_readout;
		$rose(s_r.fs_out) |-> $past(s_r.rd_go) && s_r.rd_cnt != 11'h000;
	endproperty
	a_fs_only_readout: assert property (p_fs_only_readout) else $error("stray frame sync");

	property p_window;
		s_readout_begin |-> (!s_r.win_n) [*2];
	endproperty
	a_window: assert property (p_window) else $error("window not open");

	property p_partial_wins;
		(s_r.rd_go && s_r.ctrl.scan == 2'd1 && s_r.ctrl.bin) |=> s_r.rd_cnt == `TES_LINES_HALF;
	endproperty
	a_partial_wins: assert property (p_partial_wins) else $error("binning not ignored");

	property p_full_lines;
		(s_r.rd_go && s_r.ctrl.scan == 2'd0) |=>
			s_r.rd_cnt == ($past(s_r.ctrl.bin) ? `TES_LINES_BIN : `TES_LINES_FULL);
	endproperty
	a_full_lines: assert property (p_full_lines) else $error("wrong line count");

	property p_hold;
		(s_r.st == TES_HOLD && s_r.ctrl.mode == `TES_MODE_DELAY)
			|-> if (fs_rise) (##1 s_r.rd_go) else (##1 !s_r.rd_go);
	endproperty
	a_hold: assert property (p_hold) else $error("delayed readout wrong");

	property p_long;
		(s_r.st == TES_LONG && s_r.ctrl.mode == `TES_MODE_LONG && fs_rise)
			|=> s_r.rd_go && s_r.exp ##1 s_r.fs_out;
	endproperty
	a_long: assert property (p_long) else $error("long exposure restart wrong");

	property p_startstop;
		(s_r.st == TES_EXPOSE && s_r.ctrl.mode == `TES_MODE_STARTSTOP && fs_rise)
			|=> s_r.rd_go && !s_r.exp;
	endproperty
	a_startstop: assert property (p_startstop) else $error("stop on frame sync wrong");

	// Stop and hold share the tick that follows the trailing trigger edge.
	sequence s_stop_tick;
		s_r.st == TES_WAIT_STOP && line_tick;
	endsequence

	property p_pwc_stop;
		(s_stop_tick and s_r.ctrl.mode == `TES_MODE_PWC)
			|=> !s_r.exp && s_r.rd_go;
	endproperty
	a_pwc_stop: assert property (p_pwc_stop) else $error("no stop on tick");

	property p_delay_hold;
		(s_stop_tick and s_r.ctrl.mode == `TES_MODE_DELAY)
			|=> s_r.st == TES_HOLD && !s_r.exp && !s_r.rd_go;
	endproperty
	a_delay_hold: assert property (p_delay_hold) else $error("readout not held");

	// The frame sync line comes first, so the window must still be closed then.
	property p_fs_first;
		$rose(s_r.fs_out) |-> s_r.win_n;
	endproperty
	a_fs_first: assert property (p_fs_first) else $error("window before frame sync");

	property p_fs_drop;
		(s_r.fs_out && line_tick && !s_r.rd_go) |=> !s_r.fs_out;
	endproperty
	a_fs_drop: assert property (p_fs_drop) else $error("frame sync too long");

	// A tick during readout uses up exactly one effective line.
	property p_line_count;
		(!s_r.win_n && line_tick && !s_r.rd_go)
			|=> s_r.rd_cnt == $past(s_r.rd_cnt) - 11'h001;
	endproperty
	a_line_count: assert property (p_line_count) else $error("line count step wrong");

	property p_window_close;
		(!s_r.win_n && s_r.rd_cnt == 11'h001 && line_tick && !s_r.rd_go) |=> s_r.win_n;
	endproperty
	a_window_close: assert property (p_window_close) else $error("window not closed");

	property p_long_first;
		(s_r.st == TES_IDLE && s_r.ctrl.mode == `TES_MODE_LONG && fs_rise)
			|=> s_r.exp && !s_r.rd_go;
	endproperty
	a_long_first: assert property (p_long_first) else $error("long exposure not begun");

	property p_ss_start;
		(s_r.st == TES_WAIT_START && s_r.ctrl.mode == `TES_MODE_STARTSTOP && line_tick)
			|=> s_r.exp;
	endproperty
	a_ss_start: assert property (p_ss_start) else $error("no start on tick");

	// Line-aligned start select only shortens the wait in pulse-width mode.
	property p_ss_wait;
		(s_r.st == TES_IDLE && s_r.ctrl.mode == `TES_MODE_STARTSTOP
			&& trig_rise && !line_tick)
			|=> !s_r.exp;
	endproperty
	a_ss_wait: assert property (p_ss_wait) else $error("start before line tick");
endmodule

// ---- tb/tes_partner.sv ----
`timescale 1ns/10ps
module tes_partner #(parameter int LP = 16) (
	input wire logic sys_clk,
	output logic trigger_in,
	output logic line_sync,
	output logic frame_sync
);
	int cnt = 0;
	int misses = 0;
	initial begin
		trigger_in = 1'b0;
		line_sync = 1'b0;
		frame_sync = 1'b0;
	end
	// A short line keeps the run brief; the internal timer follows it.
	always @(posedge sys_clk) begin
		cnt <= (cnt == LP - 1) ? 0 : cnt + 1;
		line_sync <= (cnt == 0);
	end
	// Each wait is bounded by one line; a missing pulse is counted for the bench.
	task automatic line_wait(input int n);
		int k;
		repeat (n) begin
			k = 0;
			do begin
				@(posedge sys_clk);
				k++;
			end while (line_sync !== 1'b1 && k < LP);
			if (line_sync !== 1'b1) begin
				misses++;
			end
		end
	endtask
	// Edges follow a line pulse by one cycle, so the start has no jitter.
	task automatic trig(input int n);
		line_wait(1);
		trigger_in <= 1'b1;
		line_wait(n);
		trigger_in <= 1'b0;
	endtask
	task automatic fsync();
		line_wait(1);
		frame_sync <= 1'b1;
		line_wait(1);
		frame_sync <= 1'b0;
	endtask
endmodule

// ---- tb/tb_triggered_exposure_sequencer.sv ----
`timescale 1ns/10ps
module tb_triggered_exposure_sequencer;
	import tes_pkg::*;
	localparam int LP = 16;
	typedef struct {
		logic [6:0] c;
		int n;
	} tes_row_s;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	tes_req_s reg_req = '0;
	logic [31:0] reg_rdata;
	logic trigger_in;
	logic line_sync;
	logic frame_sync;
	logic exposure_active_pulse;
	logic readout_window_n;
	logic frame_sync_out;
	logic fs_d = 1'b0;
	logic clr_q = 1'b0;
	int fails = 0;
	int checked = 0;
	int ec = 0;
	int wc = 0;
	int fc = 0;
	tes_row_s rows[5] = '{'{7'h02, 1220}, '{7'h42, 594}, '{7'h52, 610},
		'{7'h2a, 408}, '{7'h72, 204}};
	always #20 sys_clk = ~sys_clk;
	tes_sequencer tes_sequencer_inst (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.trigger_in(trigger_in),
		.line_sync(line_sync),
		.frame_sync(frame_sync),
		.exposure_active_pulse(exposure_active_pulse),
		.readout_window_n(readout_window_n),
		.frame_sync_out(frame_sync_out)
	);
	tes_partner #(.LP(LP)) tes_partner_inst (
		.sys_clk(sys_clk),
		.trigger_in(trigger_in),
		.line_sync(line_sync),
		.frame_sync(frame_sync)
	);
	// The counters have this one writer; the bench clears them through clr_q.
	always @(posedge sys_clk) begin
		fs_d <= frame_sync_out;
		if (clr_q) begin
			ec <= 0;
			wc <= 0;
			fc <= 0;
		end else begin
			ec <= ec + exposure_active_pulse;
			wc <= wc + !readout_window_n;
			fc <= fc + (frame_sync_out && !fs_d);
		end
	end
	task automatic complete_run();
		if (fails == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("Error %0t: got %0h want %0h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		reg_req.we <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge sys_clk);
		reg_req.re <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic clr();
		@(posedge sys_clk);
		clr_q <= 1'b1;
		@(posedge sys_clk);
		clr_q <= 1'b0;
	endtask
	task automatic wait_win(input logic lvl);
		int k;
		k = 0;
		while (readout_window_n !== lvl) begin
			@(posedge sys_clk);
			k++;
			if (k > 30000) begin
				fails++;
				complete_run();
			end
		end
	endtask
	task automatic frame(input int n);
		wait_win(1'b0);
		wait_win(1'b1);
		#1 chk(wc, n * LP);
		chk(fc, 1);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		chk({exposure_active_pulse, readout_window_n, frame_sync_out}, 3'b010);
		reset_n <= 1'b1;
		rd(4'h8, 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			wr(4'h0, rows[i].c);
			rd(4'h0, rows[i].c);
			clr();
			tes_partner_inst.trig(3);
			frame(rows[i].n);
			if (rows[i].c[3]) begin
				chk(ec > 3 * LP + 1 && ec < 4 * LP + 2, 1);
			end else begin
				chk(ec >= 3 * LP && ec <= 3 * LP + 1, 1);
			end
		end
		wr(4'h0, 32'h0000_0000);
		wr(4'h4, 32'h0000_0033);
		rd(4'h0, 32'h0000_0000);
		clr();
		tes_partner_inst.trig(3);
		tes_partner_inst.line_wait(4);
		chk(fc + ec, 0);
		wr(4'h0, 32'h0000_0033);
		clr();
		tes_partner_inst.trig(3);
		tes_partner_inst.line_wait(6);
		chk(readout_window_n, 1'b1);
		chk(fc, 0);
		rd(4'h4, 32'h0000_0004);
		tes_partner_inst.fsync();
		frame(204);
		chk(ec >= 3 * LP && ec <= 3 * LP + 1, 1);
		wr(4'h0, 32'h0000_0034);
		clr();
		tes_partner_inst.fsync();
		tes_partner_inst.line_wait(2);
		chk({exposure_active_pulse, readout_window_n}, 2'b11);
		tes_partner_inst.fsync();
		frame(204);
		chk(exposure_active_pulse, 1'b1);
		wr(4'h0, 32'h0000_0035);
		clr();
		tes_partner_inst.trig(2);
		tes_partner_inst.fsync();
		frame(204);
		chk(ec > 2 * LP && ec < 2 * LP + 4, 1);
		chk(tes_partner_inst.misses, 0);
		complete_run();
	end
endmodule
